// >>> rtl/sas_defines.vh
// Register map, field positions and timing counts of the converter sequencer
`ifndef SAS_DEFINES_VH
`define SAS_DEFINES_VH

// ****************************************************************
// Register addresses (16-bit internal address space)
// ****************************************************************
`define SAS_ADDR_MODE         16'hFF80
`define SAS_ADDR_CHAN         16'hFF84
`define SAS_ADDR_RESULT_LO    16'hFF14
`define SAS_ADDR_RESULT_HI    16'hFF15

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define SAS_MODE_RUN_BIT      7
`define SAS_MODE_TIME_MSB     5
`define SAS_MODE_TIME_LSB     3
`define SAS_MODE_WMASK        8'h_B8
`define SAS_CHAN_WMASK        8'h_07
`define SAS_MODE_RESET        8'h_00
`define SAS_CHAN_RESET        8'h_00
`define SAS_RESULT_PAD        6

// ****************************************************************
// Conversion periods in main clock cycles, per time code
// ****************************************************************
`define SAS_PERIOD_0          8'd144
`define SAS_PERIOD_1          8'd120
`define SAS_PERIOD_2          8'd96
`define SAS_PERIOD_4          8'd72
`define SAS_PERIOD_5          8'd60
`define SAS_PERIOD_6          8'd48
`define SAS_NUM_BITS          4'd10
`define SAS_SAMPLE_DIV        8'h_0A
`define SAS_STAGE_DIV         8'h_0A
`define SAS_LATER_STAGES      8'h_09

`endif

// >>> rtl/sas_timing.v
// Conversion timing: period, sampling length and stage length from code
`timescale 1ns/10ps
`default_nettype none
`include "sas_defines.vh"

module sas_timing (
  input  wire [2:0] time_code_in,
  output reg  [7:0] period_out,
  output wire [7:0] sample_len_out,
  output wire [7:0] stage_len_out,
  output reg        code_legal_out
);

  // ****************************************************************
  // Period lookup
  // ****************************************************************
  // Prohibited codes fall back to the slowest period and are flagged
  always @* begin
    code_legal_out = 1'b1;
    case (time_code_in)
      3'd0:    period_out = `SAS_PERIOD_0;
      3'd1:    period_out = `SAS_PERIOD_1;
      3'd2:    period_out = `SAS_PERIOD_2;
      3'd4:    period_out = `SAS_PERIOD_4;
      3'd5:    period_out = `SAS_PERIOD_5;
      3'd6:    period_out = `SAS_PERIOD_6;
      default: begin
        period_out     = `SAS_PERIOD_0;
        code_legal_out = 1'b0;
      end
    endcase
  end

  // Stage length rounds down; the sequencer gives the leftover cycles
  // to the first stage so the whole conversion still fills the period
  assign sample_len_out = period_out / `SAS_SAMPLE_DIV;
  assign stage_len_out  = (period_out - sample_len_out) / `SAS_STAGE_DIV;

endmodule // sas_timing
`default_nettype wire

// >>> rtl/sas_adc_seq.v
// Successive-approximation converter sequencer with its register file
`timescale 1ns/10ps
`default_nettype none
`include "sas_defines.vh"

module sas_adc_seq (
  input  wire        ref_clk_in,
  input  wire        resetn_in,
  input  wire [15:0] addr_in,
  input  wire        wr_en_in,
  input  wire [7:0]  wdata_in,
  input  wire        rd_en_in,
  output reg  [7:0]  rdata_out,
  input  wire        standby_in,
  input  wire        comp_above_in,
  output reg  [2:0]  channel_sel_out,
  output reg         sample_out,
  output reg  [9:0]  tap_code_out,
  output reg         conversion_done_irq_out,
  output wire        time_code_illegal_out
);

  // ****************************************************************
  // Reset release and input synchronisers
  // ****************************************************************
  reg       rst_meta_reg;
  reg       rst_sync_reg;
  reg [1:0] cmp_sync_reg;
  reg [1:0] stby_sync_reg;
  wire      rst_n = rst_sync_reg;

  // Reset asserts at once, releases through two flops
  always @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Comparator and standby arrive from outside the clock domain
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cmp_sync_reg  <= 2'b00;
      stby_sync_reg <= 2'b00;
    end else begin
      cmp_sync_reg  <= {cmp_sync_reg[0], comp_above_in};
      stby_sync_reg <= {stby_sync_reg[0], standby_in};
    end
  end
  wire cmp_above = cmp_sync_reg[1];
  wire standby   = stby_sync_reg[1];

  // ****************************************************************
  // Registers and decode
  // ****************************************************************
  reg  [7:0] converter_mode_reg;
  reg  [7:0] input_channel_select_reg;
  reg  [9:0] conversion_result_reg;
  reg  [9:0] approximation_reg;

  wire wr_mode   = wr_en_in && (addr_in == `SAS_ADDR_MODE);
  wire wr_chan   = wr_en_in && (addr_in == `SAS_ADDR_CHAN);
  wire ctrl_wr   = wr_mode || wr_chan;
  wire next_run  = wdata_in[`SAS_MODE_RUN_BIT];
  wire conversion_run_bit = converter_mode_reg[`SAS_MODE_RUN_BIT];

  wire [2:0] time_code =
    converter_mode_reg[`SAS_MODE_TIME_MSB:`SAS_MODE_TIME_LSB];
  wire [7:0] period_len;
  wire [7:0] sample_len;
  wire [7:0] stage_len;
  wire       code_legal;

  sas_timing u_timing (
    .time_code_in   (time_code),
    .period_out     (period_len),
    .sample_len_out (sample_len),
    .stage_len_out  (stage_len),
    .code_legal_out (code_legal)
  );
  assign time_code_illegal_out = ~code_legal;

  // First stage absorbs the rounding remainder of the stage length
  wire [7:0] first_len = period_len - sample_len -
                         stage_len * `SAS_LATER_STAGES;

  // Only defined bits are stored; unused bits read zero
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      converter_mode_reg       <= `SAS_MODE_RESET;
      input_channel_select_reg <= `SAS_CHAN_RESET;
    end else begin
      if (wr_mode)
        converter_mode_reg <= wdata_in & `SAS_MODE_WMASK;
      if (wr_chan)
        input_channel_select_reg <= wdata_in & `SAS_CHAN_WMASK;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  localparam ST_SELECT  = 2'd0;
  localparam ST_SAMPLE  = 2'd1;
  localparam ST_COMPARE = 2'd2;

  reg  [1:0] state_reg;
  reg  [7:0] cnt_reg;
  reg  [3:0] bit_idx_reg;
  wire [9:0] bit_mask = 10'h_001 << bit_idx_reg;
  wire       cnt_end  = (cnt_reg == 8'd1);
  wire       last_cmp = (state_reg == ST_COMPARE) && cnt_end &&
                        (bit_idx_reg == 4'd0);
  // Completion is cancelled by a coinciding control write
  wire       complete = last_cmp && !ctrl_wr;

  // The comparator is read on the last cycle of each stage so the
  // tap has had the whole stage less the output register and synchroniser delay to settle
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg         <= ST_SELECT;
      cnt_reg           <= 8'd0;
      bit_idx_reg       <= 4'd0;
      approximation_reg <= 10'h_000;
    end else if (standby || (wr_mode && !next_run)) begin
      state_reg <= ST_SELECT;
    end else if (ctrl_wr) begin
      // Abort; restart from sampling when run stays set
      if ((wr_mode && next_run) || (wr_chan && conversion_run_bit)) begin
        state_reg <= ST_SAMPLE;
        cnt_reg   <= sample_len;
      end else begin
        state_reg <= ST_SELECT;
      end
    end else begin
      case (state_reg)
        ST_SELECT: begin
          if (conversion_run_bit) begin
            state_reg <= ST_SAMPLE;
            cnt_reg   <= sample_len;
          end
        end
        ST_SAMPLE: begin
          if (cnt_end) begin
            state_reg         <= ST_COMPARE;
            cnt_reg           <= first_len;
            bit_idx_reg       <= `SAS_NUM_BITS - 4'd1;
            approximation_reg <= 10'h_200;
          end else begin
            cnt_reg <= cnt_reg - 8'd1;
          end
        end
        ST_COMPARE: begin
          if (cnt_end) begin
            // Keep the trial bit only when input is at or above tap
            if (!cmp_above)
              approximation_reg <= approximation_reg & ~bit_mask;
            if (bit_idx_reg == 4'd0) begin
              state_reg <= ST_SAMPLE;
              cnt_reg   <= sample_len;
            end else begin
              approximation_reg <= (cmp_above ? approximation_reg :
                (approximation_reg & ~bit_mask)) | (bit_mask >> 1);
              bit_idx_reg <= bit_idx_reg - 4'd1;
              cnt_reg     <= stage_len;
            end
          end else begin
            cnt_reg <= cnt_reg - 8'd1;
          end
        end
        default: state_reg <= ST_SELECT;
      endcase
    end
  end

  // Final code including the bit decided in the last stage
  wire [9:0] final_code = cmp_above ? approximation_reg :
                          (approximation_reg & ~bit_mask);

  // ****************************************************************
  // Result register and completion request
  // ****************************************************************
  // Reset value carries no meaning; zero is loaded only to keep it known
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      conversion_result_reg   <= 10'h_000;
      conversion_done_irq_out <= 1'b0;
    end else begin
      conversion_done_irq_out <= complete && !standby;
      // Read data is sampled this edge from the old value, so a
      // coinciding read sees the old result and the update follows
      if (complete && !standby)
        conversion_result_reg <= final_code;
    end
  end

  // ****************************************************************
  // Analog-side drive and read data
  // ****************************************************************
  wire [15:0] result_word = {conversion_result_reg,
                             {`SAS_RESULT_PAD{1'b0}}};

  // Registered outputs toward the multiplexer, sampler and tap selector
  always @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      channel_sel_out <= 3'd0;
      sample_out      <= 1'b0;
      tap_code_out    <= 10'h_000;
      rdata_out       <= 8'h_00;
    end else begin
      channel_sel_out <= input_channel_select_reg[2:0];
      sample_out      <= (state_reg == ST_SAMPLE);
      tap_code_out    <= approximation_reg;
      if (rd_en_in) begin
        case (addr_in)
          `SAS_ADDR_MODE:      rdata_out <= converter_mode_reg;
          `SAS_ADDR_CHAN:      rdata_out <= input_channel_select_reg;
          `SAS_ADDR_RESULT_LO: rdata_out <= result_word[7:0];
          `SAS_ADDR_RESULT_HI: rdata_out <= result_word[15:8];
          default:             rdata_out <= 8'h_00;
        endcase
      end
    end
  end

endmodule // sas_adc_seq
`default_nettype wire

// >>> tb/sas_seq_chk_assertions.sv
// Port checker for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
`include "sas_defines.vh"
module sas_seq_chk (
  input wire logic        ref_clk_in,
  input wire logic        resetn_in,
  input wire logic [15:0] addr_in,
  input wire logic        wr_en_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        rd_en_in,
  input wire logic [7:0]  rdata_out,
  input wire logic        standby_in,
  input wire logic        sample_out,
  input wire logic [2:0]  channel_sel_out,
  input wire logic        conversion_done_irq_out,
  input wire logic        time_code_illegal_out
);
  wire irq = conversion_done_irq_out;
  wire wm = wr_en_in && addr_in == `SAS_ADDR_MODE;
  wire wc = wr_en_in && addr_in == `SAS_ADDR_CHAN;
  wire rm = rd_en_in && addr_in == `SAS_ADDR_MODE;
  wire rc = rd_en_in && addr_in == `SAS_ADDR_CHAN;
  wire rl = rd_en_in && addr_in == `SAS_ADDR_RESULT_LO;
  logic [7:0] mode_reg, len_reg;
  logic [2:0] chan_reg;
  logic       wr_d_reg;
  wire run = mode_reg[7];
  // Shadows of the last writes, length of the running sample pulse;
  // a control write restarts sampling, so the count starts over too
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_reg <= 8'h00;
      chan_reg <= 3'h0;
      len_reg <= 8'h00;
      wr_d_reg <= 1'b0;
    end else begin
      if (wm) mode_reg <= wdata_in;
      if (wc) chan_reg <= wdata_in[2:0];
      wr_d_reg <= wm || wc;
      len_reg <= (sample_out && !wr_d_reg) ? len_reg + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  a_irq_single: assert property (irq |=> !irq)
    else $error("done too long");
  a_irq_run: assert property (irq |-> run || $past(run))
    else $error("done without run");
  a_stop_quiet: assert property (wm && !wdata_in[7] |->
    ##3 (!irq && !sample_out) [*8]) else $error("no halt");
  a_standby_stop: assert property (standby_in [*6] |->
    !irq && !sample_out) else $error("runs in standby");
  a_chan_route: assert property (wc |-> ##3 channel_sel_out == chan_reg)
    else $error("wrong input");
  a_chan_back: assert property (wc ##[1:2] rc |=>
    rdata_out == {5'h00, chan_reg}) else $error("channel readback");
  a_mode_back: assert property (wm ##[1:2] rm |=>
    rdata_out == (mode_reg & `SAS_MODE_WMASK)) else $error("mode readback");
  a_code_flag: assert property (wm |=>
    time_code_illegal_out == (mode_reg[4] && mode_reg[3]))
    else $error("code flag");
  a_result_pad: assert property (rl |=> rdata_out[5:0] == 6'h00)
    else $error("low bits set");
  a_sample_len: assert property ($fell(sample_out) |->
    len_reg <= 8'h0E) else $error("sampling long");
  c_done: cover property (irq);
  c_stop: cover property (wm && !wdata_in[7]);
  c_standby: cover property (standby_in [*6]);
endmodule // sas_seq_chk
bind sas_adc_seq sas_seq_chk u_sas_seq_chk (.ref_clk_in, .resetn_in,
  .addr_in, .wr_en_in, .wdata_in, .rd_en_in, .rdata_out, .standby_in,
  .sample_out, .channel_sel_out, .conversion_done_irq_out,
  .time_code_illegal_out);
`default_nettype wire

// >>> tb/sas_analog_model.sv
// Analog side stand-in: fixed input levels, sampler and comparator
`timescale 1ns/10ps
`default_nettype none
module sas_analog_model (
  input  wire logic       clk_in,
  input  wire logic [2:0] chan_in,
  input  wire logic       sample_in,
  input  wire logic [9:0] tap_in,
  output logic            comp_out
);
  logic [10:0] hold_reg = 11'h000;
  // Level 256*chan+101 half steps, frozen once sampling ends
  always @(posedge clk_in) begin
    if (sample_in) hold_reg <= {chan_in, 8'h65};
  end
  // Taps sit half a step low, so the code found is the rounded level
  assign comp_out =
    {1'b0, hold_reg} + 12'h001 >= {1'b0, tap_in, 1'b0};
endmodule // sas_analog_model
`default_nettype wire

// >>> tb/test_sar_adc_sequencer.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
`include "sas_defines.vh"
module test_sar_adc_sequencer;
  logic        ref_clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [15:0] addr_in = 16'h0000;
  logic        wr_en_in = 1'b0;
  logic [7:0]  wdata_in = 8'h00;
  logic        rd_en_in = 1'b0;
  logic        standby_in = 1'b0;
  wire  [7:0]  rdata_out;
  wire  [2:0]  channel_sel_out;
  wire  [9:0]  tap_code_out;
  wire         comp_above_in, sample_out, time_code_illegal_out;
  wire         conversion_done_irq_out;
  wire  [7:0]  flag = {7'h00, time_code_illegal_out};
  int          err_count = 0;
  int          comparisons = 0;
  int          n;
  logic [7:0]  d, hi;
  always #10 ref_clk_in = ~ref_clk_in;
  sas_adc_seq u_sas_adc_seq (.ref_clk_in, .resetn_in, .addr_in, .wr_en_in,
    .wdata_in, .rd_en_in, .rdata_out, .standby_in, .comp_above_in,
    .channel_sel_out, .sample_out, .tap_code_out, .conversion_done_irq_out,
    .time_code_illegal_out);
  sas_analog_model u_sas_analog_model (.clk_in(ref_clk_in),
    .chan_in(channel_sel_out), .sample_in(sample_out),
    .tap_in(tap_code_out), .comp_out(comp_above_in));
  task check(input logic [7:0] seen, exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One register access; read data lands in d
  task bus(input logic w, input logic [15:0] a, input logic [7:0] v);
    @(posedge ref_clk_in) #1;
    addr_in = a;
    wdata_in = v;
    wr_en_in = w;
    rd_en_in = !w;
    @(posedge ref_clk_in) #1;
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    d = rdata_out;
  endtask
  // Cycles up to the next done pulse, n equals lim when none came
  task wait_irq(input int lim);
    n = 0;
    do begin
      @(posedge ref_clk_in) #1;
      n++;
    end while (conversion_done_irq_out !== 1'b1 && n < lim);
  endtask
  task t_regs();
    bus(0, `SAS_ADDR_MODE, 8'h00);
    check(d, 8'h00, "mode reset");
    bus(0, `SAS_ADDR_CHAN, 8'h00);
    check(d, 8'h00, "chan reset");
    bus(0, 16'h0000, 8'h00);
    check(d, 8'h00, "unmapped");
    bus(1, `SAS_ADDR_CHAN, 8'hFF);
    bus(0, `SAS_ADDR_CHAN, 8'h00);
    check(d, 8'h07, "chan bits");
    bus(1, `SAS_ADDR_MODE, 8'h7F);
    bus(0, `SAS_ADDR_MODE, 8'h00);
    check(d, 8'h38, "mode bits");
    check(flag, 8'h01, "code flag");
    wait_irq(200);
    check(8'(n), 8'hC8, "idle");
  endtask
  // Rounding of 256*ch+101 half steps gives code 128*ch+51
  task t_codes();
    for (int ch = 0; ch < 8; ch++) begin
      bus(1, `SAS_ADDR_CHAN, 8'(ch));
      bus(1, `SAS_ADDR_MODE, 8'h80);
      wait_irq(400);
      wait_irq(400);
      bus(0, `SAS_ADDR_RESULT_HI, 8'h00);
      hi = d;
      bus(0, `SAS_ADDR_RESULT_LO, 8'h00);
      check(hi, 8'(ch * 32 + 12), "result hi");
      check(d, 8'hC0, "result lo");
    end
  endtask
  // Prohibited codes fall back to the slowest period
  task t_periods();
    int per [8] = '{144, 120, 96, 144, 72, 60, 48, 144};
    for (int c = 0; c < 8; c++) begin
      bus(1, `SAS_ADDR_MODE, {2'b10, 3'(c), 3'b000});
      check(flag, 8'(c % 4 == 3), "code flag");
      wait_irq(400);
      wait_irq(400);
      check(8'(n), 8'(per[c]), "period");
    end
  endtask
  task t_abort();
    wait_irq(400);
    repeat (60) @(posedge ref_clk_in);
    bus(1, `SAS_ADDR_CHAN, 8'h03);
    wait_irq(400);
    check(8'(n), 8'h90, "restart");
    repeat (60) @(posedge ref_clk_in);
    bus(1, `SAS_ADDR_MODE, 8'h00);
    wait_irq(200);
    check(8'(n), 8'hC8, "halt");
  endtask
  task t_standby();
    bus(1, `SAS_ADDR_MODE, 8'h80);
    wait_irq(400);
    repeat (40) @(posedge ref_clk_in);
    #1 standby_in = 1'b1;
    wait_irq(200);
    check(8'(n), 8'hC8, "standby");
    standby_in = 1'b0;
    wait_irq(400);
    check(8'(n < 400), 8'h01, "resume");
  endtask
  // A read and then a write each meet a completion edge exactly: a full
  // period is 144 cycles and a bus call samples two edges after its start
  task t_clash();
    wait_irq(400);
    bus(1, `SAS_ADDR_CHAN, 8'h05);
    repeat (142) @(posedge ref_clk_in);
    bus(0, `SAS_ADDR_RESULT_HI, 8'h00);
    check(d, 8'h6C, "clash read old");
    bus(0, `SAS_ADDR_RESULT_HI, 8'h00);
    check(d, 8'hAC, "clash read new");
    repeat (140) @(posedge ref_clk_in);
    bus(1, `SAS_ADDR_CHAN, 8'h03);
    check(8'(conversion_done_irq_out), 8'h00, "clash irq");
    wait_irq(400);
    check(8'(n), 8'h90, "clash restart");
    bus(0, `SAS_ADDR_RESULT_HI, 8'h00);
    check(d, 8'h6C, "clash result");
  endtask
  task give_verdict();
    $display("checks %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk_in);
    #1 resetn_in = 1'b1;
    repeat (3) @(posedge ref_clk_in);
    t_regs();
    t_codes();
    t_periods();
    t_abort();
    t_standby();
    t_clash();
    give_verdict();
  end
  // Watchdog far beyond the run length
  initial begin
    #400000;
    err_count++;
    give_verdict();
  end
endmodule // test_sar_adc_sequencer
`default_nettype wire
